// ===== common/fsf_pkg.sv
package fsf_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int         NCH        = 4;       // synthesizer channels
    localparam int         NPROF      = 8;       // single-tone profiles per channel
    localparam int         PSEL_W     = 3;       // profile select pins per channel
    localparam int         PORT_W     = 8;       // discrete output port width
    localparam logic [5:0] FRAME_BITS = 6'h28;   // command byte plus four data bytes
    localparam logic [5:0] CMD_BITS   = 6'h08;   // command byte length

    // ------------------------------------------------------------
    // command byte fields
    // ------------------------------------------------------------
    localparam int         CMD_RD_BIT   = 39;    // read flag position within the frame
    localparam int         CMD_ADDR_MSB = 36;    // address field, top bit
    localparam int         CMD_ADDR_LSB = 32;    // address field, low bit

    // ------------------------------------------------------------
    // register map and reset values
    // ------------------------------------------------------------
    localparam logic [4:0]  ADDR_CTRL   = 5'h00;        // channel control word
    localparam logic [4:0]  ADDR_PROF0  = 5'h0e;        // first profile word
    localparam logic [4:0]  NPROF_A     = 5'h08;        // profile count, address width
    localparam int          CTRL_PD_BIT   = 0;          // internal power-down request
    localparam int          CTRL_RAMP_BIT = 1;          // digital ramp enable
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam logic [31:0] PROF_RESET  = 32'h0000_0000;

    // ------------------------------------------------------------
    // discrete output port layout
    // ------------------------------------------------------------
    localparam int PORT_MRST_LSB = 0;             // master resets, channel four first
    localparam int PORT_UPD_LSB  = 4;             // transfer strobes, channel one first

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CH_UNINIT = 2'b00,                        // never initialized
        CH_RUN    = 2'b01,                        // operating
        CH_SLEEP  = 2'b10,                        // internal power-down
        CH_RESET  = 2'b11                         // held in master reset
    } fsf_chan_e;

    typedef struct packed {
        logic       rd;                           // read request
        logic [4:0] addr;                         // register address
        logic [1:0] ch;                           // channel index, 0 is channel one
        logic [31:0] data;                        // write data
    } fsf_xfer_s;

endpackage : fsf_pkg

// ===== rtl/fsf_fanout.sv
module fsf_fanout
    import fsf_pkg::*;
(
    // system clock and reset
    input  wire logic                    clock_in,
    input  wire logic                    rst_b_in,
    // serial link, link clock domain
    input  wire logic                    link_sclk_in,
    input  wire logic                    shared_buffer_reset_line_n_in,
    input  wire logic [NCH-1:0]          select_line_n_in,
    input  wire logic                    link_mosi_in,
    output logic                         link_miso_out,
    output logic                         link_miso_oe_n_out,
    // discrete lines from the host
    input  wire logic [PORT_W-1:0]       discrete_output_port_in,
    input  wire logic [NCH*PSEL_W-1:0]   profile_sel_in,
    // channel status
    output logic [NCH-1:0]               chan_ready_out,
    output logic [NCH-1:0]               chan_pwr_dn_out,
    output logic [NCH-1:0]               chan_ramp_out
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;                        // release stages
    logic [1:0] rst_sync_d;
    logic       rst_n;                             // released reset

    // shift a one in after release
    always_comb begin
        rst_sync_d = {rst_sync_q[0], 1'b1};
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= rst_sync_d;
        end
    end

    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // link side: frame shifter
    // ------------------------------------------------------------
    logic        cs_act;                           // some channel selected
    logic        link_arst_n;                      // frame reset
    logic [1:0]  sel_ch;                           // selected channel index
    logic [5:0]  cnt_q, cnt_d;                     // bits received in frame
    logic [38:0] sh_q, sh_d;                       // received bits
    logic        done;                             // last bit on this edge
    fsf_xfer_s   xfer_q, xfer_d;                   // finished transfer
    logic        tog_q, tog_d;                     // transfer event toggle
    logic [31:0] hold_q, hold_d;                   // read data for next frame
    logic        hold_ok_q, hold_ok_d;             // channel answered the read
    logic [5:0]  rem;                              // bits left in frame

    assign cs_act = ~&select_line_n_in;
    // select lines and buffer reset clear the shifter, not the registers
    assign link_arst_n = rst_n & shared_buffer_reset_line_n_in & cs_act;

    // reverse mapping of select lines to channels
    always_comb begin
        sel_ch = 2'd0;
        for (int k = 0; k < NCH; k++) begin
            if (!select_line_n_in[k]) begin
                sel_ch = 2'(NCH - 1 - k);
            end
        end
    end

    // next frame counter and shifter
    always_comb begin
        done  = (cnt_q == FRAME_BITS - 6'd1);
        cnt_d = (cnt_q == FRAME_BITS) ? cnt_q : cnt_q + 6'd1;
        sh_d  = {sh_q[37:0], link_mosi_in};
    end

    always_ff @(posedge link_sclk_in or negedge link_arst_n) begin
        if (!link_arst_n) begin
            cnt_q <= 6'h00;
            sh_q  <= '0;
        end else begin
            cnt_q <= cnt_d;
            sh_q  <= sh_d;
        end
    end

    // capture a finished frame and signal it
    always_comb begin
        xfer_d = xfer_q;
        tog_d  = tog_q;
        if (done) begin
            xfer_d.rd   = sh_q[CMD_RD_BIT-1];
            xfer_d.addr = sh_q[CMD_ADDR_MSB-1:CMD_ADDR_LSB-1];
            xfer_d.ch   = sel_ch;
            xfer_d.data = {sh_q[30:0], link_mosi_in};
            tog_d       = ~tog_q;
        end
    end

    // survives the end of a frame; only system reset clears it
    always_ff @(posedge link_sclk_in or negedge rst_n) begin
        if (!rst_n) begin
            xfer_q <= '0;
            tog_q  <= 1'b0;
        end else begin
            xfer_q <= xfer_d;
            tog_q  <= tog_d;
        end
    end

    // read data leaves msb first during the data bytes
    assign rem = FRAME_BITS - 6'd1 - cnt_q;
    assign link_miso_out = hold_q[rem[4:0]] & hold_ok_q;
    // uninitialized channel never drives, so a check fails
    assign link_miso_oe_n_out = ~(link_arst_n & hold_ok_q &
                                  (cnt_q >= CMD_BITS) & (cnt_q < FRAME_BITS));

    // ------------------------------------------------------------
    // system side: pin and event synchronisers
    // ------------------------------------------------------------
    localparam int SW = PORT_W + NCH*PSEL_W;       // synchronised pins

    logic [SW-1:0] pin_s1_q, pin_s2_q, pin_s3_q;   // three stages
    logic [SW-1:0] pin_flt_q, pin_flt_d;           // accepted level
    logic [SW-1:0] pin_prev_q;                     // level one cycle ago
    logic [SW-1:0] agree;                          // stages two and three match
    logic [2:0]    tg_q, tg_d;                     // toggle stages
    logic          tg_flt_q, tg_flt_d;             // accepted toggle level
    logic          ev;                             // transfer arrived

    // accept a change once stages two and three agree
    always_comb begin
        agree     = ~(pin_s2_q ^ pin_s3_q);
        pin_flt_d = (pin_s3_q & agree) | (pin_flt_q & ~agree);
        tg_d      = {tg_q[1:0], tog_q};
        tg_flt_d  = (tg_q[2] == tg_q[1]) ? tg_q[2] : tg_flt_q;
        ev        = tg_flt_d ^ tg_flt_q;
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q   <= '0;
            pin_s2_q   <= '0;
            pin_s3_q   <= '0;
            pin_flt_q  <= '0;
            pin_prev_q <= '0;
            tg_q       <= 3'b000;
            tg_flt_q   <= 1'b0;
        end else begin
            pin_s1_q   <= {profile_sel_in, discrete_output_port_in};
            pin_s2_q   <= pin_s1_q;
            pin_s3_q   <= pin_s2_q;
            pin_flt_q  <= pin_flt_d;
            pin_prev_q <= pin_flt_q;
            tg_q       <= tg_d;
            tg_flt_q   <= tg_flt_d;
        end
    end

    // ------------------------------------------------------------
    // system side: per-channel state and registers
    // ------------------------------------------------------------
    logic [31:0] rdw [NCH];                        // per-channel read word
    logic [NCH-1:0] ready;                         // channel initialized

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic [31:0]        prof_q [NPROF];        // single-tone profiles
        logic [31:0]        prof_d [NPROF];
        logic [31:0]        ctrl_q, ctrl_d;        // written control word
        logic [31:0]        act_q, act_d;          // control word in effect
        fsf_chan_e          st_q, st_d;            // lifecycle state
        logic               mrst;                  // master reset level
        logic               upd;                   // transfer strobe edge
        logic               wr;                    // write to this channel
        logic [2:0]         psel;                  // selected profile
        logic [4:0]         pidx;                  // profile offset

        assign mrst = pin_flt_q[PORT_MRST_LSB + NCH - 1 - c];
        assign upd  = pin_flt_q[PORT_UPD_LSB + c] & ~pin_prev_q[PORT_UPD_LSB + c];
        assign wr   = ev & ~xfer_q.rd & (xfer_q.ch == 2'(c));
        assign psel = pin_flt_q[PORT_W + c*PSEL_W +: PSEL_W];
        assign pidx = xfer_q.addr - ADDR_PROF0;

        // next register and lifecycle values
        always_comb begin
            prof_d = prof_q;
            ctrl_d = ctrl_q;
            act_d  = act_q;
            st_d   = st_q;
            if (mrst) begin
                // reload defaults and leave any sleep
                for (int p = 0; p < NPROF; p++) begin
                    prof_d[p] = PROF_RESET;
                end
                ctrl_d = CTRL_RESET;
                act_d  = CTRL_RESET;
                st_d   = CH_RESET;
            end else begin
                // writes land in the written copy only
                if (wr && xfer_q.addr == ADDR_CTRL) begin
                    ctrl_d = xfer_q.data;
                end
                if (wr && pidx < NPROF_A) begin
                    prof_d[pidx[2:0]] = xfer_q.data;
                end
                // strobe makes the control word take effect
                if (upd) begin
                    act_d = ctrl_q;
                end
                case (st_q)
                    CH_UNINIT: begin
                        st_d = CH_UNINIT;          // waits for a master reset
                    end
                    CH_RESET: begin
                        st_d = CH_RUN;             // released: initialized
                    end
                    CH_RUN: begin
                        // only this channel sleeps; registers kept
                        if (upd && ctrl_q[CTRL_PD_BIT]) begin
                            st_d = CH_SLEEP;
                        end
                    end
                    CH_SLEEP: begin
                        // wake returns straight to the held settings
                        if (upd && !ctrl_q[CTRL_PD_BIT]) begin
                            st_d = CH_RUN;
                        end
                    end
                    default: begin
                        st_d = CH_UNINIT;
                    end
                endcase
            end
        end

        always_ff @(posedge clock_in or negedge rst_n) begin
            if (!rst_n) begin
                for (int p = 0; p < NPROF; p++) begin
                    prof_q[p] <= PROF_RESET;
                end
                ctrl_q <= CTRL_RESET;
                act_q  <= CTRL_RESET;
                st_q   <= CH_UNINIT;
            end else begin
                prof_q <= prof_d;
                ctrl_q <= ctrl_d;
                act_q  <= act_d;
                st_q   <= st_d;
            end
        end

        // readback: any profile address gives the pin-selected profile
        always_comb begin
            if (xfer_q.addr == ADDR_CTRL) begin
                rdw[c] = ctrl_q;
            end else if (pidx < NPROF_A) begin
                rdw[c] = prof_q[psel];
            end else begin
                rdw[c] = 32'h0000_0000;            // unmapped
            end
        end

        // status outputs
        assign ready[c]           = (st_q != CH_UNINIT);
        assign chan_ready_out[c]  = ready[c];
        assign chan_pwr_dn_out[c] = (st_q == CH_SLEEP);
        // ramp bit cleared means single tone
        assign chan_ramp_out[c]   = (st_q == CH_RUN) & act_q[CTRL_RAMP_BIT];
    end

    // ------------------------------------------------------------
    // system side: read holding word
    // ------------------------------------------------------------
    // latched on a read request, shifted out in the next frame
    always_comb begin
        hold_d    = hold_q;
        hold_ok_d = hold_ok_q;
        if (ev && xfer_q.rd) begin
            hold_d    = rdw[xfer_q.ch];
            hold_ok_d = ready[xfer_q.ch];
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            hold_q    <= 32'h0000_0000;
            hold_ok_q <= 1'b0;
        end else begin
            hold_q    <= hold_d;
            hold_ok_q <= hold_ok_d;
        end
    end

endmodule : fsf_fanout

// ===== bench/fsf_fanout_assertions.sv
// ------------------------------------------------------------
// port checks on the fan-out
// ------------------------------------------------------------
module fsf_fanout_chk
    import fsf_pkg::*;
(
    // clock and reset
    input wire logic                  clock_in,
    input wire logic                  rst_b_in,
    // serial link
    input wire logic                  link_sclk_in,
    input wire logic                  shared_buffer_reset_line_n_in,
    input wire logic [NCH-1:0]        select_line_n_in,
    input wire logic                  link_mosi_in,
    input wire logic                  link_miso_out,
    input wire logic                  link_miso_oe_n_out,
    // discrete lines and status
    input wire logic [PORT_W-1:0]     discrete_output_port_in,
    input wire logic [NCH*PSEL_W-1:0] profile_sel_in,
    input wire logic [NCH-1:0]        chan_ready_out,
    input wire logic [NCH-1:0]        chan_pwr_dn_out,
    input wire logic [NCH-1:0]        chan_ramp_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_b_in);
    logic [NCH-1:0] act;  // strobe or master reset seen lately
    // eight clocks of strobe and reset history per channel
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic [7:0] uh_q;  // strobe history
        logic [7:0] rh_q;  // master reset history
        always_ff @(posedge clock_in or negedge rst_b_in) begin
            if (!rst_b_in) {uh_q, rh_q} <= 16'h0000;
            else {uh_q, rh_q} <= {uh_q[6:0], discrete_output_port_in[PORT_UPD_LSB+c],
                                  rh_q[6:0], discrete_output_port_in[PORT_MRST_LSB+NCH-1-c]};
        end
        assign act[c] = (|uh_q) || (|rh_q);
        pd_rise_a: assert property ($rose(chan_pwr_dn_out[c]) |-> |uh_q)
            else $error("power-down without strobe");
        pd_fall_a: assert property ($fell(chan_pwr_dn_out[c]) |-> act[c])
            else $error("power-down left without cause");
        ramp_chg_a: assert property ($changed(chan_ramp_out[c]) |-> act[c])
            else $error("ramp mode changed without cause");
        reset_clear_a: assert property (&rh_q |->
            chan_ready_out[c] && !chan_pwr_dn_out[c] && !chan_ramp_out[c])
            else $error("master reset left state behind");
        ready_rise_a: assert property ($rose(chan_ready_out[c]) |-> |rh_q)
            else $error("ready without master reset");
    end
    oe_uninit_a: assert property (!(|chan_ready_out) |-> link_miso_oe_n_out)
        else $error("read line driven with no channel ready");
    oe_idle_a: assert property ((&select_line_n_in) [*3] |-> link_miso_oe_n_out)
        else $error("read line driven while deselected");
    buf_keep_a: assert property (!shared_buffer_reset_line_n_in && !(|act) |=> $stable(chan_ramp_out))
        else $error("buffer reset changed channel state");
    // main scenarios reached
    cover property ($rose(chan_pwr_dn_out[0]));
    cover property ($fell(chan_ramp_out[1]));
    cover property (!link_miso_oe_n_out);
endmodule : fsf_fanout_chk
bind fsf_fanout fsf_fanout_chk chk (.clock_in(clock_in), .rst_b_in(rst_b_in), .link_sclk_in(link_sclk_in),
    .shared_buffer_reset_line_n_in(shared_buffer_reset_line_n_in), .select_line_n_in(select_line_n_in),
    .link_mosi_in(link_mosi_in), .link_miso_out(link_miso_out), .link_miso_oe_n_out(link_miso_oe_n_out),
    .discrete_output_port_in(discrete_output_port_in), .profile_sel_in(profile_sel_in),
    .chan_ready_out(chan_ready_out), .chan_pwr_dn_out(chan_pwr_dn_out), .chan_ramp_out(chan_ramp_out));

// ===== bench/fsf_host_model.sv
// ------------------------------------------------------------
// host adapter: serial master and discrete port
// ------------------------------------------------------------
module fsf_host_model
    import fsf_pkg::*;
(
    // serial link
    output logic              sclk_out,
    output logic              buf_rst_n_out,
    output logic [NCH-1:0]    cs_n_out,
    output logic              mosi_out,
    input  wire logic         miso_in,
    input  wire logic         miso_oe_n_in,
    // discrete port
    output logic [PORT_W-1:0] port_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle levels from time zero
    initial begin
        {sclk_out, mosi_out, port_out} = '0;
        buf_rst_n_out = 1'b1;
        cs_n_out = '1;
    end
    // one frame of nb bits, 64 ns each; clock stands low between frames
    task automatic xfer(input int c, input logic [39:0] w, input int nb,
                        output logic [31:0] rd, output logic drv);
        rd = 32'h0;
        drv = 1'b1;
        cs_n_out[NCH-1-c] = 1'b0;
        for (int i = 0; i < nb; i++) begin
            mosi_out = w[39-i];
            #32;
            if (i >= 8) begin
                rd = {rd[30:0], miso_oe_n_in ? ~rd[0] : miso_in};  // floating line
                drv = drv & !miso_oe_n_in;
            end
            sclk_out = 1'b1;
            #32;
            sclk_out = 1'b0;
        end
        cs_n_out = '1;
        mosi_out = ~mosi_out;  // no stale level
        #480;
    endtask : xfer
    // raise port bits ten clocks, then rest ten clocks
    task automatic pulse(input logic [PORT_W-1:0] m);
        port_out = port_out | m;
        #400;
        port_out = port_out & ~m;
        #400;
    endtask : pulse
    // shutdown: serial off, every line floated
    task automatic shut();
        {sclk_out, buf_rst_n_out, cs_n_out, mosi_out, port_out} = 'z;
    endtask : shut
    // shared buffer reset, two clocks low
    task automatic bufrst();
        buf_rst_n_out = 1'b0;
        #80;
        buf_rst_n_out = 1'b1;
    endtask : bufrst
endmodule : fsf_host_model

// ===== bench/testbench.sv
module testbench
    import fsf_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic                  clock_in, rst_b_in, sclk, brst_n, mosi, miso, oe_n;
    logic [NCH-1:0]        cs_n, ready, pd, ramp;
    logic [PORT_W-1:0]     port;
    logic [NCH*PSEL_W-1:0] psel;
    int                    n_errors = 0;
    int                    samples_checked = 0;
    fsf_fanout dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .link_sclk_in(sclk),
        .shared_buffer_reset_line_n_in(brst_n), .select_line_n_in(cs_n), .link_mosi_in(mosi),
        .link_miso_out(miso), .link_miso_oe_n_out(oe_n), .discrete_output_port_in(port),
        .profile_sel_in(psel), .chan_ready_out(ready), .chan_pwr_dn_out(pd), .chan_ramp_out(ramp));
    fsf_host_model host (.sclk_out(sclk), .buf_rst_n_out(brst_n), .cs_n_out(cs_n), .mosi_out(mosi),
        .miso_in(miso), .miso_oe_n_in(oe_n), .port_out(port));
    // compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic logic [39:0] cmd(input logic rd, input logic [4:0] a, input logic [31:0] d);
        return {rd, 2'b00, a, d};
    endfunction : cmd
    function automatic logic [NCH-1:0] one(input int c);
        return NCH'(1) << c;
    endfunction : one
    // read comes back in the following frame
    task automatic rreg(input int c, input logic [4:0] a, output logic [31:0] v, output logic k);
        host.xfer(c, cmd(1'b1, a, 32'h0), 40, v, k);
        host.xfer(c, cmd(1'b1, a, 32'h0), 40, v, k);
    endtask : rreg
    task automatic wreg(input int c, input logic [4:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic        k;
        host.xfer(c, cmd(1'b0, a, d), 40, x, k);
    endtask : wreg
    // control write then transfer strobe
    task automatic ctrl(input int c, input logic [31:0] w);
        wreg(c, ADDR_CTRL, w);
        host.pulse(PORT_W'(1) << (PORT_UPD_LSB + c));
    endtask : ctrl
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    // clock and watchdog
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    initial begin
        #2_000_000;
        n_errors++;
        report_and_stop();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        logic [31:0]    v;
        logic [31:0]    pv [NCH];
        logic           k;
        logic [NCH-1:0] er;
        int             p;
        rst_b_in = 1'b0;
        psel = '0;
        er = '0;
        void'($urandom(32'h915c));
        repeat (8) @(negedge clock_in);
        rst_b_in = 1'b1;
        repeat (4) @(negedge clock_in);
        check("ready", 32'(ready), 32'h0);
        rreg(0, ADDR_CTRL, v, k);
        check("uninit drive", 32'(k), 32'h0);
        $display("test uninitialized done");
        host.pulse(8'h0f);  // box-wide init, all channels powered
        check("ready", 32'(ready), 32'hf);
        for (int c = 0; c < NCH; c++) begin
            p = $urandom_range(NPROF - 1);
            pv[c] = $urandom;
            psel[PSEL_W*c +: PSEL_W] = PSEL_W'(p);
            wreg(c, ADDR_PROF0 + 5'(p), pv[c]);
            wreg(c, ADDR_PROF0 + 5'(p ^ 1), ~pv[c]);
            rreg(c, ADDR_PROF0 + 5'(p ^ 1), v, k);
            check("profile", v, pv[c]);
            check("drive", 32'(k), 32'h1);
            ctrl(c, 32'h2);
            er |= one(c);
            check("ramp", 32'(ramp), 32'(er));
            ctrl(c, 32'h3);
            check("pwr_dn", 32'(pd), 32'(one(c)));
            ctrl(c, 32'h2);
            check("pwr_dn", 32'(pd), 32'h0);
            check("ramp", 32'(ramp), 32'(er));
            rreg(c, ADDR_PROF0 + 5'(p), v, k);
            check("profile", v, pv[c]);
        end
        $display("test channels done");
        p = $urandom_range(NCH - 1);
        ctrl(p, 32'h0);
        er &= ~one(p);
        check("ramp", 32'(ramp), 32'(er));
        rreg(1, 5'h1f, v, k);
        check("unmapped", v, 32'h0);
        // write cut short by buffer reset must not land
        fork
            host.xfer(0, cmd(1'b0, ADDR_CTRL, 32'({~er[0], 1'b0})), 40, v, k);
            #1280 host.bufrst();
        join
        host.pulse(PORT_W'(1) << PORT_UPD_LSB);
        check("ramp", 32'(ramp), 32'(er));
        rreg(0, ADDR_PROF0, v, k);
        check("profile", v, pv[0]);
        $display("test ramp and buffer reset done");
        ctrl(1, 32'h3);
        host.pulse(8'h0f);  // box-wide init over a sleeping channel
        check("pwr_dn", 32'(pd), 32'h0);
        check("ramp", 32'(ramp), 32'h0);
        rreg(1, ADDR_CTRL, v, k);
        check("ctrl", v, CTRL_RESET);
        rreg(1, ADDR_PROF0, v, k);
        check("profile", v, PROF_RESET);
        // single-channel re-init of channel one, woken first
        ctrl(0, 32'h3);
        ctrl(0, 32'h2);
        check("ramp", 32'(ramp), 32'h1);
        host.pulse(PORT_W'(1) << (PORT_MRST_LSB + NCH - 1));
        check("pwr_dn", 32'(pd), 32'h0);
        check("ramp", 32'(ramp), 32'h0);
        rreg(0, ADDR_CTRL, v, k);
        check("ctrl", v, CTRL_RESET);
        $display("test reinit done");
        host.shut();
        report_and_stop();
    end
endmodule : testbench
